// >>> verilog/pmi_cfg.svh
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH
// bus select encodings
`define PMI_BUS_WIDE      2'h0
`define PMI_BUS_SERIAL    2'h1
`define PMI_BUS_REDUCED   2'h2
`define PMI_BUS_RSVD      2'h3
// management base address when address straps are 00
`define PMI_MGMT_BASE     5'h08
// management width strap value for 16-bit mode
`define PMI_MGMT_W16      1'h0
// register offsets of the plain register port
`define PMI_REG_STATUS    4'h0
`define PMI_REG_CTRL      4'h1
`define PMI_REG_TXDATA    4'h2
`define PMI_REG_RXDATA    4'h3
// control bit positions
`define PMI_CTRL_SPEED10  0
`define PMI_CTRL_RXER_EN  1
// error nibble sent on the medium side when receive error is flagged
`define PMI_ERR_SYMBOL    4'h5
// reference clock divider (125 MHz system, 50 MHz not integer; divide by 2 approx)
`define PMI_REFDIV        2'h1
`endif

// >>> verilog/pmi_pkg.sv
package pmi_pkg;
  // link bus types
  typedef enum logic [1:0] {
    PMI_WIDE    = 2'b00,
    PMI_SERIAL  = 2'b01,
    PMI_REDUCED = 2'b10,
    PMI_RSVD    = 2'b11
  } pmi_bus_t;
  // transmit serializer state
  typedef enum logic [1:0] {
    PMI_TX_IDLE = 2'b00,
    PMI_TX_SEND = 2'b01,
    PMI_TX_LAST = 2'b10,
    PMI_TX_DONE = 2'b11
  } pmi_tx_state_t;
endpackage

// >>> verilog/pmi_port5.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pmi_cfg.svh"
module pmi_port5 (
  input  wire logic       CLK_I,          // system clock 125 MHz
  input  wire logic       RESET_N_I,      // async reset, active low
  input  wire logic [1:0] BUS_STRAP_I,    // {hi, lo} bus select straps
  input  wire logic       MGMT_WIDTH_STRAP_I,
  input  wire logic [1:0] MGMT_ADDR_STRAP_I,
  input  wire logic       TX_LINK_CLK_I,  // wide or serial transmit clock
  input  wire logic       RX_LINK_CLK_I,  // wide or serial receive clock
  input  wire logic       REF_CLK_I,      // reduced mode reference clock
  input  wire logic [3:0] RXD_I,          // receive data pins
  input  wire logic       RX_VALID_I,     // wide rx valid or reduced carrier valid
  input  wire logic       RX_ERR_I,       // receive error pin
  input  wire logic       SPEED10_I,      // high for 10M operation
  input  wire logic [3:0] ADDR_I,         // register address
  input  wire logic [7:0] WDATA_I,        // register write data
  input  wire logic       WR_I,           // write strobe
  input  wire logic       RD_I,           // read strobe
  output logic      [7:0] RDATA_O,        // read data, one cycle after strobe
  output logic      [3:0] TXD_O,          // transmit data pins
  output logic            TX_EN_O,        // transmit enable
  output logic            REF_CLK_O,      // reference clock out in reduced mode
  output logic      [1:0] BUS_SEL_O,      // captured bus type
  output logic            MGMT_W16_O,     // high for 16-bit management mode
  output logic      [4:0] MGMT_BASE_O,    // first management address
  output logic      [7:0] RX_BYTE_O,      // received byte to core
  output logic            RX_BYTE_VLD_O,  // one-cycle strobe with rx byte
  output logic            RX_ERR_SEEN_O   // sticky flag: error symbol sent since the last status read
);
  // strap capture state
  logic       strap_done_reg, strap_done_next;
  logic [1:0] bus_reg, bus_next;
  logic       w16_reg, w16_next;
  logic [4:0] base_reg, base_next;
  // two-flop synchronisers on link clocks and rxd, valid, error and speed pins; straps are not synchronised
  logic [2:0] clk_s1_reg, clk_s2_reg, clk_s3_reg;  // tx, rx, ref clocks
  logic [3:0] rxd_s1_reg, rxd_s2_reg;
  logic       rxv_s1_reg, rxv_s2_reg;
  logic       rxe_s1_reg, rxe_s2_reg;
  logic       spd_s1_reg, spd_s2_reg;

  // pin synchronisers; third stage only for edge detection of clocks
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      clk_s1_reg <= 3'h0;
      clk_s2_reg <= 3'h0;
      clk_s3_reg <= 3'h0;
      rxd_s1_reg <= 4'h0;
      rxd_s2_reg <= 4'h0;
      rxv_s1_reg <= 1'b0;
      rxv_s2_reg <= 1'b0;
      rxe_s1_reg <= 1'b0;
      rxe_s2_reg <= 1'b0;
      spd_s1_reg <= 1'b0;
      spd_s2_reg <= 1'b0;
    end else begin
      clk_s1_reg <= {REF_CLK_I, RX_LINK_CLK_I, TX_LINK_CLK_I};
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      rxd_s1_reg <= RXD_I;
      rxd_s2_reg <= rxd_s1_reg;
      rxv_s1_reg <= RX_VALID_I;
      rxv_s2_reg <= rxv_s1_reg;
      rxe_s1_reg <= RX_ERR_I;
      rxe_s2_reg <= rxe_s1_reg;
      spd_s1_reg <= SPEED10_I;
      spd_s2_reg <= spd_s1_reg;
    end
  end

  // rising edges of link clocks seen in the system domain
  logic tx_rise, rx_rise, ref_rise;
  assign tx_rise  = clk_s2_reg[0] & ~clk_s3_reg[0];
  assign rx_rise  = clk_s2_reg[1] & ~clk_s3_reg[1];
  assign ref_rise = clk_s2_reg[2] & ~clk_s3_reg[2];

  // straps caught on the first clock after reset release, then frozen
  always_comb begin
    strap_done_next = 1'b1;
    bus_next        = bus_reg;
    w16_next        = w16_reg;
    base_next       = base_reg;
    if (!strap_done_reg) begin
      bus_next  = BUS_STRAP_I;
      w16_next  = (MGMT_WIDTH_STRAP_I == `PMI_MGMT_W16);
      base_next = `PMI_MGMT_BASE + {MGMT_ADDR_STRAP_I, 3'h0};
    end
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      strap_done_reg <= 1'b0;
      bus_reg        <= 2'h0;
      w16_reg        <= 1'b1;
      base_reg       <= `PMI_MGMT_BASE;
    end else begin
      strap_done_reg <= strap_done_next;
      bus_reg        <= bus_next;
      w16_reg        <= w16_next;
      base_reg       <= base_next;
    end
  end

  // mode decode; reserved value treated as idle
  function automatic pmi_pkg::pmi_bus_t decode_bus(input logic [1:0] sel);
    case (sel)
      `PMI_BUS_WIDE:    decode_bus = pmi_pkg::PMI_WIDE;
      `PMI_BUS_SERIAL:  decode_bus = pmi_pkg::PMI_SERIAL;
      `PMI_BUS_REDUCED: decode_bus = pmi_pkg::PMI_REDUCED;
      default:          decode_bus = pmi_pkg::PMI_RSVD;
    endcase
  endfunction
  pmi_pkg::pmi_bus_t mode;
  assign mode = decode_bus(bus_reg);

  // per-mode symbol width and strobes
  logic       tx_tick, rx_tick;
  logic [2:0] sym_w;  // bits per link clock
  always_comb begin
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    sym_w   = 3'd4;
    case (mode)
      pmi_pkg::PMI_WIDE: begin
        tx_tick = tx_rise;
        rx_tick = rx_rise;
        sym_w   = 3'd4;
      end
      // serial transmit on serial tx clock
      pmi_pkg::PMI_SERIAL: begin
        tx_tick = tx_rise;
        rx_tick = rx_rise;
        sym_w   = 3'd1;
      end
      pmi_pkg::PMI_REDUCED: begin
        tx_tick = ref_rise;
        rx_tick = ref_rise;
        sym_w   = 3'd2;
      end
      default: begin
        tx_tick = 1'b0;
        rx_tick = 1'b0;
      end
    endcase
  end

  // two-entry transmit buffer fed by register writes
  logic [7:0] buf_reg [2];
  logic [7:0] buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic       push, pop;
  logic       buf_ready;
  assign buf_ready = (cnt_reg != 2'd2);
  assign push = WR_I && (ADDR_I == `PMI_REG_TXDATA) && buf_ready;

  // transmit serializer
  pmi_pkg::pmi_tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] sh_reg, sh_next;
  logic [2:0] left_reg, left_next;
  logic [3:0] txd_reg, txd_next;
  logic       txen_reg, txen_next;
  logic       rxerr_now;

  always_comb begin
    tx_state_next = tx_state_reg;
    sh_next       = sh_reg;
    left_next     = left_reg;
    txd_next      = txd_reg;
    txen_next     = txen_reg;
    pop           = 1'b0;
    if (tx_tick) begin
      case (tx_state_reg)
        pmi_pkg::PMI_TX_IDLE: begin
          txen_next = 1'b0;
          txd_next  = 4'h0;
          if (cnt_reg != 2'd0) begin
            pop           = 1'b1;
            sh_next       = buf_reg[0];
            left_next     = 3'd0;
            tx_state_next = pmi_pkg::PMI_TX_SEND;
          end
        end
        pmi_pkg::PMI_TX_SEND: begin
          // low bits first, enable marks data valid
          txen_next = 1'b1;
          txd_next  = sh_reg[3:0] & ((4'h1 << sym_w) - 4'h1);
          sh_next   = sh_reg >> sym_w;
          left_next = left_reg + sym_w;
          if (({1'b0, left_reg} + {1'b0, sym_w}) >= 4'd8) begin
            tx_state_next = pmi_pkg::PMI_TX_IDLE;
            if (cnt_reg != 2'd0) begin
              pop           = 1'b1;
              sh_next       = buf_reg[0];
              left_next     = 3'd0;
              tx_state_next = pmi_pkg::PMI_TX_SEND;
            end
          end
        end
        default: tx_state_next = pmi_pkg::PMI_TX_IDLE;
      endcase
      // wide mode error symbol at 100M
      // reduced mode error symbol at 100M
      if (rxerr_now) begin
        txen_next = 1'b1;
        txd_next  = `PMI_ERR_SYMBOL;
      end
    end
  end

  // buffer bookkeeping
  always_comb begin
    buf_next[0] = buf_reg[0];
    buf_next[1] = buf_reg[1];
    cnt_next    = cnt_reg;
    if (pop) begin
      buf_next[0] = buf_reg[1];
      cnt_next    = cnt_reg - 2'd1;
    end
    if (push) begin
      buf_next[cnt_next[0]] = WDATA_I;
      cnt_next = cnt_next + 2'd1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_state_reg <= pmi_pkg::PMI_TX_IDLE;
      sh_reg       <= 8'h00;
      left_reg     <= 3'h0;
      txd_reg      <= 4'h0;
      txen_reg     <= 1'b0;
      buf_reg[0]   <= 8'h00;
      buf_reg[1]   <= 8'h00;
      cnt_reg      <= 2'h0;
    end else begin
      tx_state_reg <= tx_state_next;
      sh_reg       <= sh_next;
      left_reg     <= left_next;
      txd_reg      <= txd_next;
      txen_reg     <= txen_next;
      buf_reg[0]   <= buf_next[0];
      buf_reg[1]   <= buf_next[1];
      cnt_reg      <= cnt_next;
    end
  end

  // receive assembler
  logic [7:0] asm_reg, asm_next;
  logic [3:0] got_reg, got_next;  // bits collected
  logic [7:0] rxb_reg, rxb_next;
  logic       rxbv_reg, rxbv_next;
  logic       ctl_er_en_reg, ctl_er_en_next;
  logic       erseen_reg, erseen_next;
  logic       rx_dv;
  // serial mode has no valid pin; valid is taken as always high
  assign rx_dv = (mode == pmi_pkg::PMI_SERIAL) ? 1'b1 : rxv_s2_reg;
  assign rxerr_now = ctl_er_en_reg && rxe_s2_reg && !spd_s2_reg
                     && (mode == pmi_pkg::PMI_WIDE || mode == pmi_pkg::PMI_REDUCED);

  always_comb begin
    asm_next    = asm_reg;
    got_next    = got_reg;
    rxb_next    = rxb_reg;
    rxbv_next   = 1'b0;
    erseen_next = erseen_reg | (tx_tick & rxerr_now);
    if (rx_tick) begin
      // wide sample; serial sample; reduced sample
      if (rx_dv) begin
        asm_next = (asm_reg >> sym_w) | ({rxd_s2_reg, 4'h0} << (3'd4 - sym_w));
        got_next = got_reg + {1'b0, sym_w};
        if ((got_reg + {1'b0, sym_w}) >= 4'd8) begin
          rxb_next  = (asm_reg >> sym_w) | ({rxd_s2_reg, 4'h0} << (3'd4 - sym_w));
          rxbv_next = 1'b1;
          got_next  = 4'h0;
        end
      end else begin
        got_next = 4'h0;
      end
    end
    if (RD_I && ADDR_I == `PMI_REG_STATUS) begin
      erseen_next = tx_tick & rxerr_now;  // set wins over clear on read
    end
  end

  // register port and control
  logic [7:0] rdata_reg, rdata_next;
  logic       spd_cfg_reg, spd_cfg_next;
  always_comb begin
    ctl_er_en_next = ctl_er_en_reg;
    spd_cfg_next   = spd_cfg_reg;
    rdata_next     = 8'h00;
    if (WR_I && ADDR_I == `PMI_REG_CTRL) begin
      spd_cfg_next   = WDATA_I[`PMI_CTRL_SPEED10];
      ctl_er_en_next = WDATA_I[`PMI_CTRL_RXER_EN];
    end
    if (RD_I) begin
      case (ADDR_I)
        `PMI_REG_STATUS: rdata_next = {erseen_reg, w16_reg, cnt_reg, bus_reg, spd_s2_reg, buf_ready};
        `PMI_REG_CTRL:   rdata_next = {6'h00, ctl_er_en_reg, spd_cfg_reg};
        `PMI_REG_RXDATA: rdata_next = rxb_reg;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      asm_reg       <= 8'h00;
      got_reg       <= 4'h0;
      rxb_reg       <= 8'h00;
      rxbv_reg      <= 1'b0;
      erseen_reg    <= 1'b0;
      ctl_er_en_reg <= 1'b1;
      spd_cfg_reg   <= 1'b0;
      rdata_reg     <= 8'h00;
    end else begin
      asm_reg       <= asm_next;
      got_reg       <= got_next;
      rxb_reg       <= rxb_next;
      rxbv_reg      <= rxbv_next;
      erseen_reg    <= erseen_next;
      ctl_er_en_reg <= ctl_er_en_next;
      spd_cfg_reg   <= spd_cfg_next;
      rdata_reg     <= rdata_next;
    end
  end

  // reference clock output: toggles each cycle in reduced mode only
  logic refo_reg, refo_next;
  assign refo_next = (mode == pmi_pkg::PMI_REDUCED) ? ~refo_reg : 1'b0;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      refo_reg <= 1'b0;
    end else begin
      refo_reg <= refo_next;
    end
  end

  assign RDATA_O       = rdata_reg;
  assign TXD_O         = txd_reg;
  assign TX_EN_O       = txen_reg;
  assign REF_CLK_O     = refo_reg;
  assign BUS_SEL_O     = bus_reg;
  assign MGMT_W16_O    = w16_reg;
  assign MGMT_BASE_O   = base_reg;
  assign RX_BYTE_O     = rxb_reg;
  assign RX_BYTE_VLD_O = rxbv_reg;
  assign RX_ERR_SEEN_O = erseen_reg;
endmodule
`default_nettype wire

// >>> bench/pmi_port5_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pmi_port5_checker (
  input  wire logic       CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [1:0] BUS_STRAP_I,
  input  wire logic       MGMT_WIDTH_STRAP_I,
  input  wire logic [1:0] MGMT_ADDR_STRAP_I,
  input  wire logic       TX_LINK_CLK_I,
  input  wire logic       REF_CLK_I,
  input  wire logic       RX_ERR_I,
  input  wire logic       SPEED10_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] RDATA_O,
  input  wire logic [3:0] TXD_O,
  input  wire logic       TX_EN_O,
  input  wire logic       REF_CLK_O,
  input  wire logic [1:0] BUS_SEL_O,
  input  wire logic       MGMT_W16_O,
  input  wire logic [4:0] MGMT_BASE_O,
  input  wire logic       RX_BYTE_VLD_O,
  input  wire logic       RX_ERR_SEEN_O
);
  logic lclk; // transmit clock of the captured bus type
  assign lclk = (BUS_SEL_O == 2'h2) ? REF_CLK_I : TX_LINK_CLK_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  bus_capture_a: assert property ($rose(RESET_N_I) |=> BUS_SEL_O == $past(BUS_STRAP_I))
    else $error("bus type differs from strap");
  width_capture_a: assert property ($rose(RESET_N_I) |=> MGMT_W16_O == !$past(MGMT_WIDTH_STRAP_I))
    else $error("management width differs from strap");
  base_capture_a: assert property ($rose(RESET_N_I) && MGMT_ADDR_STRAP_I == 2'h0 |=> MGMT_BASE_O == 5'h08)
    else $error("management base wrong");
  // straps settle one edge after release; later pin changes must not leak through
  strap_hold_a: assert property ($past(RESET_N_I, 3) |-> $stable({BUS_SEL_O, MGMT_W16_O, MGMT_BASE_O}))
    else $error("captured settings changed");
  // outputs move only a few cycles after a link clock rise, never late in its low phase
  tx_quiet_a: assert property ((!lclk) [*4] |-> $stable({TX_EN_O, TXD_O}))
    else $error("transmit pins moved away from link edge");
  err_symbol_a: assert property ((RX_ERR_I && !SPEED10_I && BUS_SEL_O != 2'h1) [*8] |-> ##[0:24] (TX_EN_O && TXD_O == 4'h5))
    else $error("error symbol not sent");
  err_slow_a: assert property (SPEED10_I [*8] |-> !$rose(RX_ERR_SEEN_O))
    else $error("error symbol at 10M");
  ref_clk_a: assert property ($past(BUS_SEL_O, 2) == 2'h2 && BUS_SEL_O == 2'h2 |-> REF_CLK_O != $past(REF_CLK_O))
    else $error("reference clock out not toggling");
  unmapped_read_a: assert property (RD_I && ADDR_I > 4'h3 |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  cover property ($rose(RX_ERR_SEEN_O));
  cover property (RX_BYTE_VLD_O);
  cover property (BUS_SEL_O == 2'h2 && TX_EN_O);
endmodule
bind pmi_port5 pmi_port5_checker chk_u (.CLK_I, .RESET_N_I, .BUS_STRAP_I, .MGMT_WIDTH_STRAP_I, .MGMT_ADDR_STRAP_I,
  .TX_LINK_CLK_I, .REF_CLK_I, .RX_ERR_I, .SPEED10_I, .ADDR_I, .RD_I, .RDATA_O, .TXD_O, .TX_EN_O, .REF_CLK_O,
  .BUS_SEL_O, .MGMT_W16_O, .MGMT_BASE_O, .RX_BYTE_VLD_O, .RX_ERR_SEEN_O);
`default_nettype wire

// >>> bench/pmi_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmi_link_model (
  input  wire logic [1:0] mode,     // 0 wide, 1 serial, 2 reduced
  input  wire logic [3:0] txd,      // device transmit pins
  input  wire logic       tx_en,    // device transmit enable
  output logic            clk,      // one clock serves all link clock inputs
  output logic      [3:0] rxd,      // receive pins toward the device
  output logic            rx_valid  // receive valid or carrier-valid
);
  logic [7:0] tx_sh;    // partial byte
  logic [7:0] tx_byte;  // last whole byte seen
  int         tx_n;     // bits gathered so far
  int         tx_count; // whole bytes seen
  int         w;        // unit width of the bus
  assign w = (mode == 2'h0) ? 4 : (mode == 2'h1) ? 1 : 2;
  initial begin
    clk = 1'b0;
    rxd = 4'h0;
    rx_valid = 1'b0;
    tx_n = 0;
    tx_count = 0;
    forever #32 clk = ~clk;
  end
  // units gathered lsb first on the rising edge
  always @(posedge clk) begin
    if (tx_en === 1'b1) begin
      tx_sh = (tx_sh >> w) | (8'(txd & 4'((1 << w) - 1)) << (8 - w));
      tx_n = tx_n + w;
      if (tx_n == 8) begin
        tx_byte = tx_sh;
        tx_count++;
        tx_n = 0;
      end
    end else begin
      tx_n = 0;
    end
  end
  // data moves on the falling edge so it is steady at the rise
  task automatic send_byte(input logic [7:0] b);
    for (int k = 0; k < 8; k += w) begin
      @(negedge clk);
      rxd <= 4'(b >> k) & 4'((1 << w) - 1);
      rx_valid <= 1'b1;
    end
    @(negedge clk);
    rxd <= 4'h0; // pull-downs take released lines low
    rx_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/port5_media_independent_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port5_media_independent_if_tb;
  logic       clk, rst_n, w16s, rxer, spd10, wr_s, rd_s, txen, refo, w16, bvld, seen, lclk, rxv;
  logic [1:0] bstr, astr, bsel, mode;
  logic [3:0] addr, txd, rxd;
  logic [7:0] wdat, rdat, rxb, d;
  logic [4:0] base;
  int         mismatches, n_tests, m;
  pmi_port5 dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .BUS_STRAP_I(bstr), .MGMT_WIDTH_STRAP_I(w16s),
    .MGMT_ADDR_STRAP_I(astr), .TX_LINK_CLK_I(lclk), .RX_LINK_CLK_I(lclk), .REF_CLK_I(lclk), .RXD_I(rxd),
    .RX_VALID_I(rxv), .RX_ERR_I(rxer), .SPEED10_I(spd10), .ADDR_I(addr), .WDATA_I(wdat), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdat), .TXD_O(txd), .TX_EN_O(txen), .REF_CLK_O(refo), .BUS_SEL_O(bsel),
    .MGMT_W16_O(w16), .MGMT_BASE_O(base), .RX_BYTE_O(rxb), .RX_BYTE_VLD_O(bvld), .RX_ERR_SEEN_O(seen));
  pmi_link_model far_u (.mode(mode), .txd(txd), .tx_en(txen), .clk(lclk), .rxd(rxd), .rx_valid(rxv));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdat;
  endtask
  // reset with straps, then move the strap pins to show they are ignored
  task automatic do_reset(input logic [1:0] md, input logic ws);
    @(posedge clk);
    rst_n <= 1'b0;
    bstr <= md;
    w16s <= ws;
    astr <= 2'h0;
    mode <= md;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bstr <= ~md;
    w16s <= ~ws;
    astr <= 2'h3;
    repeat (4) @(posedge clk);
    #1;
    chk("bus_sel", {6'h0, md}, {6'h0, bsel});
    chk("mgmt_w16", {7'h0, ~ws}, {7'h0, w16});
    chk("mgmt_base", 8'h08, {3'h0, base});
  endtask
  task automatic wait_tx(input logic [7:0] exp);
    int c0;
    c0 = far_u.tx_count;
    for (int k = 0; k < 400 && far_u.tx_count == c0; k++) @(posedge clk);
    chk("tx_done", 8'h01, {7'h0, far_u.tx_count != c0});
    chk("tx_byte", exp, far_u.tx_byte);
  endtask
  task automatic rx_check(input logic [7:0] b);
    fork
      far_u.send_byte(b);
    join_none
    for (int k = 0; k < 400 && bvld !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("rx_seen", 8'h01, {7'h0, bvld});
    chk("rx_byte", b, rxb);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: all tests need well under 25k cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    {bstr, astr, w16s, rxer, spd10, addr, wdat, wr_s, rd_s, mode} = '0;
    mismatches = 0;
    n_tests = 0;
    // wide, serial and reduced: strap decode, one byte out; one byte in except in serial
    for (m = 0; m < 3; m++) begin
      do_reset(m[1:0], m == 1);
      reg_wr(4'h2, 8'hA5 ^ 8'(m * 8'h33));
      wait_tx(8'hA5 ^ 8'(m * 8'h33));
      if (m != 1) begin
        rx_check(8'h5A ^ 8'(m));
        reg_rd(4'h3, d);
        chk("rx_reg", 8'h5A ^ 8'(m), d);
      end
      reg_rd(4'h1, d);
      chk("ctrl_reset", 8'h02, d);
      reg_rd(4'h0, d);
      chk("status_bus", {6'h0, m[1:0]}, {6'h0, d[3:2]});
      reg_rd(4'hF, d);
      chk("unmapped", 8'h00, d);
      $display("test mode %0d done", m);
    end
    // receive error: silent at 10M, error symbol at 100M
    for (m = 0; m < 3; m += 2) begin
      do_reset(m[1:0], 1'b0);
      spd10 <= 1'b1;
      rxer <= 1'b1;
      repeat (80) @(posedge clk);
      chk("err_10m", 8'h00, {7'h0, seen});
      spd10 <= 1'b0;
      repeat (80) @(posedge clk);
      #1;
      chk("err_100m", 8'h01, {7'h0, seen});
      chk("err_sym", 8'h15, {3'h0, txen, txd});
      rxer <= 1'b0;
      $display("test error mode %0d done", m);
    end
    conclude();
  end
endmodule
`default_nettype wire
